// ---- shared/blc_pkg.sv ----
// constants for the black level calibration control block
// assumes one 25 MHz clock and a simple internal register write port
package blc_pkg;
   localparam logic [7:0] THR_ADDR = 8'h5F;
   localparam logic [7:0] CAL_ADDR = 8'h62;
   localparam logic [15:0] THR_RST = 16'h0000;
   localparam logic [15:0] CAL_RST = 16'h07F8;
   localparam int THR_GAIN_INDEP = 15;
   localparam int THR_HI_MSB = 14;
   localparam int THR_HI_LSB = 8;
   localparam int THR_OVERRIDE = 7;
   localparam int THR_LO_MSB = 5;
   localparam int CAL_NO_SWEEP = 15;
   localparam int CAL_RESTART = 12;
   localparam int CAL_KEEP_HI = 11;
   localparam int CAL_CONT = 2;
   localparam int CAL_DISABLE = 1;
   localparam int CAL_MANUAL = 0;
   localparam logic [6:0] HI_MARGIN = 7'h05;
   localparam logic [9:0] JUMP_BASE = 10'h002;
   localparam logic [9:0] JUMP_NEAR_LIM = 10'h040;
   localparam logic [9:0] JUMP_MID_LIM = 10'h077;
   localparam logic [9:0] JUMP_ADD = 10'h004;
   localparam logic [6:0] CEIL_CAP = 7'h7B;
   localparam logic [6:0] CEIL_MAX = 7'h7F;
   localparam logic [6:0] FLOOR_MAX = 7'h3F;
   localparam logic [6:0] CEIL_RST = 7'h05;
   localparam int FILT_SHIFT = 3;
   localparam logic signed [8:0] OFS_MAX = 9'sh0FF;
   localparam logic signed [8:0] OFS_MIN = -9'sh100;
   localparam logic signed [8:0] OFS_RST = 9'sh000;
   localparam logic [9:0] LVL_RST = 10'h000;
endpackage : blc_pkg

// ---- design/blc_floor_calc.sv ----
// automatic lower black level limit from the four gain settings
// assumes gain inputs are stable registers on the same clock
`timescale 1ns/1ps
`default_nettype none
module blc_floor_calc (
   input wire logic [7:0] gain0_i, // gain setting colour 0
   input wire logic [7:0] gain1_i, // gain setting colour 1
   input wire logic [7:0] gain2_i, // gain setting colour 2
   input wire logic [7:0] gain3_i, // gain setting colour 3
   output logic [7:0] largest_gain_setting_o, // largest of the four
   output logic [6:0] auto_floor_o // derived lower limit
);
   function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
      return (a > b) ? a : b;
   endfunction : max8

   wire logic [7:0] largest = max8(max8(gain0_i, gain1_i), max8(gain2_i, gain3_i));
   // times (bit6+1) times (bit7+1) is a left shift by bit6+bit7
   wire logic [1:0] shift = {1'b0, largest[6]} + {1'b0, largest[7]};
   wire logic [7:0] scaled = 8'({2'b00, largest[7:2]} << shift);
   // the limit field is six bits wide, so the derived value saturates there [RULE5]
   assign auto_floor_o = (scaled > {1'b0, blc_pkg::FLOOR_MAX}) ? blc_pkg::FLOOR_MAX :
                         scaled[6:0];
   assign largest_gain_setting_o = largest;
endmodule : blc_floor_calc
`default_nettype wire

// ---- design/blc_ctrl.sv ----
// black level calibration control: limits, jump tracking, restart, offsets
// assumes the serial decoder gives one-cycle register writes and event pulses
// Function
// RULE1: gain-independent: lower limit is the field; upper reloads from field on restart.
// RULE2: with gain-independence off, both limits are derived automatically.
// RULE3: automatic upper limit defaults to lower limit plus five.
// RULE4: override bit: both limits always follow their fields, no automatic adjust.
// RULE5: automatic lower limit is largest gain over four, scaled by bits six, seven.
// RULE6: upward jump to level under 64: upper becomes lower plus two plus twice overshoot.
// RULE7: upward jump to 64..118 sets upper to level plus four; above 119, 123.
// RULE8: after every average restart the upper limit is restored unless keep is set.
// RULE9: sweep-suppress bit skips the rapid sweep following new settings.
// RULE10: software keeps reserved bits 14:13 at zero and 10:3 at one.
// RULE11: writing restart starts a new average and sweep; the bit reads back zero.
// RULE12: keep bit set means the upper limit is not restored after a sweep.
// RULE13: mode field: during conversion, continuous, or disabled with zero offsets.
// RULE14: manual bit replaces automatic offsets with software values.
// RULE15: average below lower raises offset one step; above upper lowers it.
// RULE16: settings change, recalc or restart resets filter to the first dark average.
// RULE17: a new level of exactly 119 after a jump is capped like above 119.
`timescale 1ns/1ps
`default_nettype none
module blc_ctrl (
   input wire logic mclk_i, // master clock
   input wire logic nrst_i, // async reset, active low
   input wire logic [7:0] reg_addr_i, // register address
   input wire logic [15:0] reg_wdata_i, // write data
   input wire logic reg_we_i, // write strobe, one cycle
   output logic [15:0] reg_rdata_o, // read data, one cycle after address
   input wire logic [7:0] gain0_i, // gain setting colour 0
   input wire logic [7:0] gain1_i, // gain setting colour 1
   input wire logic [7:0] gain2_i, // gain setting colour 2
   input wire logic [7:0] gain3_i, // gain setting colour 3
   input wire logic config_change_i, // gain or timing register changed, pulse
   input wire logic recalc_req_i, // recalc or reset bit set, pulse
   input wire logic adc_active_i, // converter is running
   input wire logic dark_valid_i, // dark row averages ready, pulse
   input wire logic [9:0] dark_avg0_i, // dark average colour 0
   input wire logic [9:0] dark_avg1_i, // dark average colour 1
   input wire logic [9:0] dark_avg2_i, // dark average colour 2
   input wire logic [9:0] dark_avg3_i, // dark average colour 3
   input wire logic [8:0] man_offset0_i, // software offset colour 0
   input wire logic [8:0] man_offset1_i, // software offset colour 1
   input wire logic [8:0] man_offset2_i, // software offset colour 2
   input wire logic [8:0] man_offset3_i, // software offset colour 3
   output logic [8:0] offset0_o, // applied offset colour 0
   output logic [8:0] offset1_o, // applied offset colour 1
   output logic [8:0] offset2_o, // applied offset colour 2
   output logic [8:0] offset3_o, // applied offset colour 3
   output logic cal_apply_o, // offset correction enabled now
   output logic sweep_start_o, // start rapid sweep, pulse
   output logic avg_restart_o, // running average restarted, pulse
   output logic [6:0] black_floor_limit_o, // lower limit in use
   output logic [6:0] black_ceiling_limit_o // upper limit in use
);
   function automatic logic [9:0] filt(input logic [9:0] avg, input logic [9:0] s);
      return avg - (avg >> blc_pkg::FILT_SHIFT) + (s >> blc_pkg::FILT_SHIFT);
   endfunction : filt

   function automatic logic [6:0] jump_ceiling(input logic [9:0] lvl, input logic [6:0] lo);
      logic [9:0] v;
      v = 10'h000;
      if (lvl < blc_pkg::JUMP_NEAR_LIM) begin
         v = {3'b000, lo} + blc_pkg::JUMP_BASE + 10'((lvl - {3'b000, lo}) << 1); // [RULE6]
      end else if (lvl < blc_pkg::JUMP_MID_LIM) begin
         v = lvl + blc_pkg::JUMP_ADD; // [RULE7]
      end else begin
         v = {3'b000, blc_pkg::CEIL_CAP}; // [RULE7] [RULE17]
      end
      return (v > {3'b000, blc_pkg::CEIL_MAX}) ? blc_pkg::CEIL_MAX : v[6:0];
   endfunction : jump_ceiling

   function automatic logic signed [8:0] ofs_step(input logic signed [8:0] o,
         input logic [9:0] lvl, input logic [6:0] lo, input logic [6:0] hi);
      if (lvl < {3'b000, lo} && o != blc_pkg::OFS_MAX) begin
         return o + 9'sh001; // [RULE15]
      end else if (lvl > {3'b000, hi} && o != blc_pkg::OFS_MIN) begin
         return o - 9'sh001; // [RULE15]
      end
      return o;
   endfunction : ofs_step

   logic [15:0] thr_reg, cal_reg, rdata_reg;
   logic [6:0] ceiling_reg, floor_out_reg, ceiling_out_reg;
   logic pending_reg, boot_reg, sweep_reg, restart_reg, apply_reg;
   logic [9:0] avg_reg [4];
   logic signed [8:0] auto_ofs_reg [4];
   logic [8:0] ofs_out_reg [4];
   logic [9:0] samp [4];
   logic [8:0] man_ofs [4];
   logic [9:0] new_lvl [4];
   logic [6:0] auto_floor;
   logic jump_hit;
   logic [9:0] jump_lvl;

   assign samp[0] = dark_avg0_i;
   assign samp[1] = dark_avg1_i;
   assign samp[2] = dark_avg2_i;
   assign samp[3] = dark_avg3_i;
   assign man_ofs[0] = man_offset0_i;
   assign man_ofs[1] = man_offset1_i;
   assign man_ofs[2] = man_offset2_i;
   assign man_ofs[3] = man_offset3_i;

   blc_floor_calc u_floor (
      .gain0_i(gain0_i),
      .gain1_i(gain1_i),
      .gain2_i(gain2_i),
      .gain3_i(gain3_i),
      .largest_gain_setting_o(),
      .auto_floor_o(auto_floor)
   );

   wire logic thr_wr = reg_we_i && (reg_addr_i == blc_pkg::THR_ADDR);
   wire logic cal_wr = reg_we_i && (reg_addr_i == blc_pkg::CAL_ADDR);
   // the restart bit acts on the write itself and is never stored [RULE11]
   wire logic restart_wr = cal_wr && reg_wdata_i[blc_pkg::CAL_RESTART];
   wire logic [15:0] cal_wval = reg_wdata_i & ~(16'h0001 << blc_pkg::CAL_RESTART);
   wire logic gain_indep = thr_reg[blc_pkg::THR_GAIN_INDEP];
   wire logic override = thr_reg[blc_pkg::THR_OVERRIDE];
   wire logic [6:0] field_lo = {1'b0, thr_reg[blc_pkg::THR_LO_MSB:0]};
   wire logic [6:0] field_hi = thr_reg[blc_pkg::THR_HI_MSB:blc_pkg::THR_HI_LSB];
   wire logic keep_hi = cal_reg[blc_pkg::CAL_KEEP_HI];
   wire logic no_sweep = cal_reg[blc_pkg::CAL_NO_SWEEP];
   wire logic cal_off = cal_reg[blc_pkg::CAL_DISABLE];
   wire logic cal_cont = cal_reg[blc_pkg::CAL_CONT];
   wire logic manual = cal_reg[blc_pkg::CAL_MANUAL];

   wire logic [6:0] floor_eff = (override || gain_indep) ? field_lo : auto_floor; // [RULE1] [RULE2] [RULE4]
   wire logic avg_restart = restart_wr || recalc_req_i || config_change_i; // [RULE16]
   // suppression only holds back settings changes; an explicit restart always sweeps
   wire logic sweep_now = restart_wr || recalc_req_i || (config_change_i && !no_sweep); // [RULE9] [RULE11]
   wire logic restore_evt = (avg_restart && !keep_hi) || boot_reg; // [RULE8] [RULE12]
   wire logic [6:0] restore_val = gain_indep ? field_hi : 7'(floor_eff + blc_pkg::HI_MARGIN); // [RULE1] [RULE3]
   wire logic [6:0] ceiling_eff = override ? field_hi : ceiling_reg; // [RULE4]
   wire logic [6:0] jump_val = jump_ceiling(jump_lvl, floor_eff);
   wire logic [6:0] ceiling_next = restore_evt ? restore_val :
                                   (jump_hit && !override) ? jump_val : ceiling_reg; // [RULE4]
   // a restart in the same cycle as a sample keeps the filter waiting: set wins
   wire logic pending_next = avg_restart || (pending_reg && !dark_valid_i);
   wire logic [15:0] rdata_next = (reg_addr_i == blc_pkg::THR_ADDR) ? thr_reg :
                                  (reg_addr_i == blc_pkg::CAL_ADDR) ? cal_reg : 16'h0000;

   always_comb begin
      for (int c = 0; c < 4; c++) begin
         new_lvl[c] = pending_reg ? samp[c] : filt(avg_reg[c], samp[c]); // [RULE16]
      end
   end

   // lowest colour wins when several jump in the same frame
   always_comb begin
      jump_hit = 1'b0;
      jump_lvl = 10'h000;
      for (int c = 3; c >= 0; c--) begin
         if (dark_valid_i && !pending_reg && avg_reg[c] < {3'b000, floor_eff} &&
             new_lvl[c] > {3'b000, ceiling_eff}) begin
            jump_hit = 1'b1;
            jump_lvl = new_lvl[c];
         end
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         thr_reg <= blc_pkg::THR_RST;
         cal_reg <= blc_pkg::CAL_RST;
         rdata_reg <= 16'h0000;
         ceiling_reg <= blc_pkg::CEIL_RST;
         floor_out_reg <= blc_pkg::CEIL_RST;
         ceiling_out_reg <= blc_pkg::CEIL_RST;
         pending_reg <= 1'b1;
         boot_reg <= 1'b1;
         sweep_reg <= 1'b0;
         restart_reg <= 1'b0;
         apply_reg <= 1'b0;
      end else begin
         if (thr_wr) begin
            thr_reg <= reg_wdata_i;
         end
         if (cal_wr) begin
            cal_reg <= cal_wval;
         end
         rdata_reg <= rdata_next;
         ceiling_reg <= ceiling_next;
         floor_out_reg <= floor_eff;
         ceiling_out_reg <= ceiling_eff;
         pending_reg <= pending_next;
         boot_reg <= 1'b0;
         sweep_reg <= sweep_now;
         restart_reg <= avg_restart;
         apply_reg <= !cal_off && (cal_cont || adc_active_i); // [RULE13]
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int c = 0; c < 4; c++) begin
            avg_reg[c] <= blc_pkg::LVL_RST;
            auto_ofs_reg[c] <= blc_pkg::OFS_RST;
            ofs_out_reg[c] <= 9'h000;
         end
      end else begin
         for (int c = 0; c < 4; c++) begin
            if (dark_valid_i) begin
               avg_reg[c] <= new_lvl[c];
            end
            if (dark_valid_i && !manual) begin
               auto_ofs_reg[c] <= ofs_step(auto_ofs_reg[c], new_lvl[c], floor_eff, ceiling_eff);
            end
            ofs_out_reg[c] <= cal_off ? 9'h000 : manual ? man_ofs[c] : auto_ofs_reg[c]; // [RULE13] [RULE14]
         end
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign offset0_o = ofs_out_reg[0];
   assign offset1_o = ofs_out_reg[1];
   assign offset2_o = ofs_out_reg[2];
   assign offset3_o = ofs_out_reg[3];
   assign cal_apply_o = apply_reg;
   assign sweep_start_o = sweep_reg;
   assign avg_restart_o = restart_reg;
   assign black_floor_limit_o = floor_out_reg;
   assign black_ceiling_limit_o = ceiling_out_reg;

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   sequence restart_write_s;
      cal_wr && reg_wdata_i[blc_pkg::CAL_RESTART];
   endsequence
   sequence restart_effect_s;
      sweep_start_o && avg_restart_o && !cal_reg[blc_pkg::CAL_RESTART];
   endsequence

   gi_floor_a: assert property (gain_indep && !override |=> // [RULE1]
      black_floor_limit_o == {1'b0, $past(thr_reg[5:0])})
      else $error("floor does not follow field in gain-independent mode");
   auto_ceiling_a: assert property (restore_evt && !gain_indep |=> // [RULE3]
      ceiling_reg == 7'($past(floor_eff) + 7'h05))
      else $error("automatic ceiling not floor plus five after restart");
   auto_floor_a: assert property (!gain_indep && !override |=> // [RULE2]
      black_floor_limit_o == $past(auto_floor))
      else $error("floor not automatic");
   ovr_limits_a: assert property (override |=> // [RULE4]
      black_ceiling_limit_o == $past(thr_reg[14:8]) && black_floor_limit_o == $past(field_lo))
      else $error("override limits do not follow fields");
   jump_near_a: assert property (jump_hit && !override && !restore_evt && jump_lvl < 10'h040 // [RULE6]
      |=> ceiling_reg == 7'(($past(jump_lvl) << 1) - {3'b000, $past(floor_eff)} + 10'h002))
      else $error("near jump ceiling wrong");
   jump_high_a: assert property (jump_hit && !override && !restore_evt && jump_lvl >= 10'h077 // [RULE7]
      |=> ceiling_reg == 7'h7B)
      else $error("high jump ceiling not capped");
   jump_mid_a: assert property (jump_hit && !override && !restore_evt && jump_lvl > 10'h03F // [RULE7]
      && jump_lvl < 10'h077 |=> ceiling_reg == 7'($past(jump_lvl) + 10'h004))
      else $error("mid jump ceiling wrong");
   sweep_supp_a: assert property (config_change_i && no_sweep && !recalc_req_i && !restart_wr // [RULE9]
      |=> !sweep_start_o ##1 !sweep_start_o || $past(sweep_now))
      else $error("sweep not suppressed");
   restart_self_a: assert property (restart_write_s |=> restart_effect_s) // [RULE11]
      else $error("restart did not sweep or did not self clear");
   keep_hi_a: assert property (avg_restart && keep_hi && !boot_reg && !jump_hit // [RULE12]
      |=> $stable(ceiling_reg))
      else $error("ceiling restored while keep bit set");
   cal_off_a: assert property (cal_off [*2] |-> offset0_o == 9'h000 && !cal_apply_o) // [RULE13]
      else $error("disabled mode still corrects");
   manual_ofs_a: assert property (manual && !cal_off |=> offset2_o == $past(man_offset2_i)) // [RULE14]
      else $error("manual offset not applied");
   step_up_a: assert property (dark_valid_i && !manual && new_lvl[0] < {3'b000, floor_eff} // [RULE15]
      && auto_ofs_reg[0] != 9'sh0FF |=> auto_ofs_reg[0] == $past(auto_ofs_reg[0]) + 9'sh001)
      else $error("offset not raised below floor");
   // the first sample after a restart may come one or two cycles later; both load raw
   first_avg_a: assert property ((avg_restart ##1 dark_valid_i) or // [RULE16]
      (avg_restart ##1 !dark_valid_i ##1 dark_valid_i) |=> avg_reg[1] == $past(dark_avg1_i))
      else $error("filter not reset to first average");
endmodule : blc_ctrl
`default_nettype wire

// ---- testbench/tb.sv ----
// self-checking bench for the black level calibration control block
// assumes blc_ctrl alone on one 25 MHz clock, every port driven by this bench
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct packed {
      logic [15:0] thr;
      logic [7:0] g;
      logic [6:0] fl;
      logic [6:0] ce;
   } blc_row_t;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic reg_we_i = 1'b0;
   logic [7:0] gain_i [4] = '{8'h20, 8'h20, 8'h20, 8'h20};
   logic config_change_i = 1'b0;
   logic recalc_req_i = 1'b0;
   logic adc_active_i = 1'b0;
   logic dark_valid_i = 1'b0;
   logic [9:0] dark_avg_i = 10'h000;
   logic [8:0] man_i [4] = '{9'h1F3, 9'h0FF, 9'h100, 9'h005};
   logic [15:0] reg_rdata_o;
   logic [8:0] offset_o [4];
   logic cal_apply_o;
   logic sweep_start_o;
   logic avg_restart_o;
   logic [6:0] floor_o;
   logic [6:0] ceil_o;
   logic [15:0] rv;
   int bad_count = 0;
   int checked = 0;
   int cyc = 0;
   // ordinary cases: threshold word, largest gain, expected lower and upper limit
   blc_row_t rows [7] = '{'{16'h0000, 8'h20, 7'h08, 7'h0D}, '{16'h0000, 8'h51, 7'h28, 7'h2D},
      '{16'h0000, 8'h08, 7'h02, 7'h07}, '{16'h0000, 8'h67, 7'h32, 7'h37},
      '{16'h0000, 8'hA0, 7'h3F, 7'h44}, '{16'hB012, 8'hA0, 7'h12, 7'h30},
      '{16'h258A, 8'hA0, 7'h0A, 7'h25}};
   // jump sample (filter starts at 0, so the new level is sample/8) and resulting ceiling
   logic [9:0] jump_s [6] = '{10'h0A0, 10'h1F8, 10'h200, 10'h320, 10'h3B8, 10'h3F8};
   logic [6:0] jump_c [6] = '{7'h22, 7'h78, 7'h44, 7'h68, 7'h7B, 7'h7B};
   logic [15:0] mode_w [5] = '{16'h07F8, 16'h07F8, 16'h07FC, 16'h07FE, 16'h07FA};
   logic mode_a [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
   logic mode_e [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

   blc_ctrl dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_rdata_o(reg_rdata_o),
      .gain0_i(gain_i[0]), .gain1_i(gain_i[1]), .gain2_i(gain_i[2]), .gain3_i(gain_i[3]),
      .config_change_i(config_change_i), .recalc_req_i(recalc_req_i),
      .adc_active_i(adc_active_i), .dark_valid_i(dark_valid_i),
      .dark_avg0_i(dark_avg_i), .dark_avg1_i(dark_avg_i), .dark_avg2_i(dark_avg_i),
      .dark_avg3_i(dark_avg_i), .man_offset0_i(man_i[0]), .man_offset1_i(man_i[1]),
      .man_offset2_i(man_i[2]), .man_offset3_i(man_i[3]), .offset0_o(offset_o[0]),
      .offset1_o(offset_o[1]), .offset2_o(offset_o[2]), .offset3_o(offset_o[3]),
      .cal_apply_o(cal_apply_o), .sweep_start_o(sweep_start_o),
      .avg_restart_o(avg_restart_o), .black_floor_limit_o(floor_o),
      .black_ceiling_limit_o(ceil_o));

   always #20 mclk_i = ~mclk_i;

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish

   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_we_i <= 1'b1;
      tick(1);
      reg_we_i <= 1'b0;
   endtask : wr

   // read data is registered, so it is looked at one edge after the address
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge mclk_i);
      reg_addr_i <= a;
      tick(1);
      v = reg_rdata_o;
   endtask : rd

   // m = {dark_valid, recalc, config_change}; returns one edge after the pulses, with them cleared and their registered outputs standing
   task automatic strobe(input logic [2:0] m, input logic [9:0] s);
      @(posedge mclk_i);
      {dark_valid_i, recalc_req_i, config_change_i} <= m;
      dark_avg_i <= s;
      tick(1);
      {dark_valid_i, recalc_req_i, config_change_i} <= 3'b000;
   endtask : strobe

   task automatic chk_ofs(input logic [8:0] e0, input logic [8:0] e1);
      for (int k = 0; k < 4; k++) begin
         chk("offset", {7'h00, offset_o[k]}, (k == 0) ? {7'h00, e0} : {7'h00, e1});
      end
   endtask : chk_ofs

   initial begin
      tick(10);
      chk("floor in reset", {9'h000, floor_o}, 16'h0005);
      chk("ceiling in reset", {9'h000, ceil_o}, 16'h0005);
      chk_ofs(9'h000, 9'h000);
      repeat (10) @(posedge mclk_i);
      nrst_i <= 1'b1;
      tick(2);
      rd(blc_pkg::THR_ADDR, rv);
      chk("threshold reset", rv, blc_pkg::THR_RST);
      rd(blc_pkg::CAL_ADDR, rv);
      chk("calibration reset", rv, blc_pkg::CAL_RST);
      chk("boot ceiling", {9'h000, ceil_o}, 16'h000D);
      foreach (rows[i]) begin
         wr(blc_pkg::THR_ADDR, rows[i].thr);
         @(posedge mclk_i);
         for (int k = 0; k < 4; k++) begin
            gain_i[k] <= (k == i % 4) ? rows[i].g : rows[i].g >> 1;
         end
         strobe(3'b001, 10'h000);
         tick(2);
         chk("floor", {9'h000, floor_o}, {9'h000, rows[i].fl});
         chk("ceiling", {9'h000, ceil_o}, {9'h000, rows[i].ce});
         rd(blc_pkg::THR_ADDR, rv);
         chk("threshold readback", rv, rows[i].thr);
      end
      wr(blc_pkg::THR_ADDR, 16'h0000);
      @(posedge mclk_i);
      gain_i <= '{8'h20, 8'h20, 8'h20, 8'h20};
      strobe(3'b001, 10'h000);
      tick(2);
      strobe(3'b100, 10'h000);
      tick(2);
      chk_ofs(9'h001, 9'h001);
      strobe(3'b001, 10'h000);
      strobe(3'b100, 10'h009);
      strobe(3'b100, 10'h030);
      tick(2);
      chk_ofs(9'h000, 9'h000);
      chk("ceiling no jump", {9'h000, ceil_o}, 16'h000D);
      foreach (jump_s[j]) begin
         strobe(3'b001, 10'h000);
         strobe(3'b100, 10'h000);
         strobe(3'b100, jump_s[j]);
         tick(2);
         chk("jump ceiling", {9'h000, ceil_o}, {9'h000, jump_c[j]});
      end
      wr(blc_pkg::CAL_ADDR, 16'h0FF8);
      strobe(3'b001, 10'h000);
      tick(2);
      chk("kept ceiling", {9'h000, ceil_o}, 16'h007B);
      wr(blc_pkg::CAL_ADDR, 16'h07F8);
      strobe(3'b010, 10'h000);
      chk("recalc restart", {15'h0000, avg_restart_o}, 16'h0001);
      chk("recalc sweep", {15'h0000, sweep_start_o}, 16'h0001);
      tick(2);
      chk("restored ceiling", {9'h000, ceil_o}, 16'h000D);
      wr(blc_pkg::CAL_ADDR, 16'h87F8);
      strobe(3'b001, 10'h000);
      chk("suppressed restart", {15'h0000, avg_restart_o}, 16'h0001);
      chk("suppressed sweep", {15'h0000, sweep_start_o}, 16'h0000);
      wr(blc_pkg::CAL_ADDR, 16'h97F8);
      chk("restart sweep", {15'h0000, sweep_start_o}, 16'h0001);
      chk("restart average", {15'h0000, avg_restart_o}, 16'h0001);
      rd(blc_pkg::CAL_ADDR, rv);
      chk("restart self clear", rv, 16'h87F8);
      rd(8'h60, rv);
      chk("unmapped read", rv, 16'h0000);
      // first sample after the restart is below the floor, so the offsets are non-zero
      strobe(3'b100, 10'h000);
      foreach (mode_w[m]) begin
         wr(blc_pkg::CAL_ADDR, mode_w[m]);
         adc_active_i <= mode_a[m];
         tick(2);
         chk("cal apply", {15'h0000, cal_apply_o}, {15'h0000, mode_e[m]});
      end
      chk_ofs(9'h000, 9'h000);
      wr(blc_pkg::CAL_ADDR, 16'h07F9);
      strobe(3'b100, 10'h000);
      tick(2);
      for (int k = 0; k < 4; k++) begin
         chk("manual offset", {7'h00, offset_o[k]}, {7'h00, man_i[k]});
      end
      // reset again in mid-run: manual offsets and the manual bit must not survive it
      @(posedge mclk_i);
      nrst_i <= 1'b0;
      tick(2);
      chk_ofs(9'h000, 9'h000);
      chk("ceiling in reset", {9'h000, ceil_o}, 16'h0005);
      @(posedge mclk_i);
      nrst_i <= 1'b1;
      tick(2);
      chk("boot ceiling", {9'h000, ceil_o}, 16'h000D);
      rd(blc_pkg::CAL_ADDR, rv);
      chk("calibration after reset", rv, blc_pkg::CAL_RST);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
